// File: design/serial_adaptor_pkg.sv
// Shared constants and carrier types for the serial adaptor core
package serial_adaptor_pkg;
    // Register select codes (reg_sel_hi, reg_sel_lo)
    localparam logic [1:0] SEL_DATA   = 2'h0;
    localparam logic [1:0] SEL_STATUS = 2'h1;
    localparam logic [1:0] SEL_CMD    = 2'h2;
    localparam logic [1:0] SEL_FMT    = 2'h3;
    // Status bit positions
    localparam int ST_PAR  = 0;
    localparam int ST_FRM  = 1;
    localparam int ST_OVR  = 2;
    localparam int ST_RXF  = 3;
    localparam int ST_TXE  = 4;
    localparam int ST_DCD  = 5;
    localparam int ST_DSR  = 6;
    localparam int ST_IRQ  = 7;
    // Command register fields
    localparam int CMD_DTR  = 0;
    localparam int CMD_RXID = 1;
    localparam int CMD_TXC  = 2;
    localparam int CMD_ECHO = 4;
    localparam int CMD_PAR  = 5;
    localparam logic [1:0] TXC_OFF   = 2'h0;
    localparam logic [1:0] TXC_IRQ   = 2'h1;
    localparam logic [1:0] TXC_ON    = 2'h2;
    localparam logic [1:0] TXC_BREAK = 2'h3;
    // Format register fields
    localparam int FMT_STOP = 7;
    localparam int FMT_WLEN = 5;
    // Reset values
    localparam logic [7:0] CMD_RST    = 8'h00;
    localparam logic [7:0] FMT_RST    = 8'h00;
    localparam logic [7:0] CMD_SWMASK = 8'hE0;
    // Oversampling
    localparam int OVS = 16;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] OVS_HALF = 4'h8;
    localparam logic [3:0] RXIRQ_PT = 4'h8;
    // Baud divider default: 25 MHz over 16x of 9600 baud
    localparam int CLK_HZ  = 25_000_000;
    localparam int BAUD_HZ = 9600;
    localparam int DIV16   = CLK_HZ / (BAUD_HZ * OVS);

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tx_word_t;

    typedef struct packed {
        logic [3:0] nbits;
        logic       par_en;
        logic       par_odd;
        logic       par_force;
        logic       par_level;
        logic [5:0] stop16;
    } fmt_t;
endpackage

// File: design/word_buf2.sv
// Two-entry valid/ready buffer for received words
`timescale 1ns/1ps
module word_buf2 #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic [1:0]   cnt_r, cnt_nxt;
    logic         rd_r, rd_nxt, wr_r, wr_nxt;
    logic         push, pop;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        rd_nxt  = rd_r;
        wr_nxt  = wr_r;
        if (push) begin
            mem_nxt[wr_r] = in_data;
            wr_nxt = ~wr_r;
        end
        if (pop) begin
            rd_nxt = ~rd_r;
        end
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            cnt_nxt = 2'h0;
            rd_nxt  = 1'b0;
            wr_nxt  = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_r <= 2'h0;
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
        end
        mem_r <= mem_nxt;
    end
endmodule

// File: design/async_serial_adaptor_core.sv
// Asynchronous serial adaptor core: bus registers, transmitter, receiver, modem lines
// Functional notes
// - error flags clear after read plus clean word
// - status bit 3 is receive full, read clears
// - status bit 4 transmit empty, write clears
// - bits 5,6 mirror carrier and ready inputs
// - bit 7 interrupt pending, status read clears
// - command bits 2,3 set RTS; RTS high stops transmit
// - DTR low when command bit 0 set
// - CTS negated abandons word, holding word kept
// - DSR edge interrupts once until status read
// - no carrier disables receiver, drops word
// - carrier edges interrupt; even changes ignored
// - access needs both selects and E high
// - status address write is software reset
// - idle transmitter loads written word immediately
// - unused upper data bits ignored
// - write during shifting held, latest kept
// - empty flag always; interrupt at start bit
// - unserviced empty re-interrupts each bit time
// - received word sets full; interrupt 9/16 stop
// - receiver turned off finishes current word
// - break gives one zero word, then waits
// - transmit control codes set interrupt, RTS, break
// - command bit 0 clear disables receiver, interrupts
`timescale 1ns/1ps
module async_serial_adaptor_core
    import serial_adaptor_pkg::*;
#(
    parameter int DIV = DIV16
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       select_a,
    input  wire logic       select_b_n,
    input  wire logic       e_strobe,
    input  wire logic       rd_wr,
    input  wire logic       reg_sel_lo,
    input  wire logic       reg_sel_hi,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe,
    output logic            irq_n,
    input  wire logic       rxd,
    output logic            txd,
    output logic            rts_n,
    output logic            dtr_n,
    input  wire logic       cts_n,
    input  wire logic       dsr_n,
    input  wire logic       dcd_n
);
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BRK} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_WAIT} rx_state_t;

    // Two-flop synchronisers on rxd and the three modem inputs
    logic [3:0] sync1_r, sync2_r;
    always_ff @(posedge mclk) begin
        sync1_r <= {rxd, cts_n, dsr_n, dcd_n};
        sync2_r <= sync1_r;
    end
    logic rxd_s, cts_s, dsr_s, dcd_s;
    assign {rxd_s, cts_s, dsr_s, dcd_s} = sync2_r;

    // 16x tick divider
    logic [15:0] div_r, div_nxt;
    logic        tick;
    assign tick = (div_r == 16'(DIV - 1));
    always_comb div_nxt = tick ? 16'h0000 : div_r + 16'h0001;

    // Bus access: both selects and E high
    logic acc_r, acc_nxt, access, acc_start;
    logic [1:0] sel;
    assign access    = select_a && !select_b_n && e_strobe;
    assign acc_nxt   = access;
    assign acc_start = access && !acc_r;
    assign sel       = {reg_sel_hi, reg_sel_lo};
    logic wr_data, wr_stat, wr_cmd, wr_fmt, rd_data, rd_stat;
    assign wr_data = acc_start && !rd_wr && sel == SEL_DATA;
    assign wr_stat = acc_start && !rd_wr && sel == SEL_STATUS;
    assign wr_cmd  = acc_start && !rd_wr && sel == SEL_CMD;
    assign wr_fmt  = acc_start && !rd_wr && sel == SEL_FMT;
    assign rd_data = acc_start && rd_wr && sel == SEL_DATA;
    assign rd_stat = acc_start && rd_wr && sel == SEL_STATUS;

    logic [7:0] cmd_r, cmd_nxt, fmt_r, fmt_nxt;
    logic [7:0] status;
    logic [1:0] txc;
    logic       dtr_on, txirq_en, rxirq_en, tx_allowed;
    assign txc        = cmd_r[CMD_TXC +: 2];
    assign dtr_on     = cmd_r[CMD_DTR];
    assign rxirq_en   = dtr_on && !cmd_r[CMD_RXID];
    assign txirq_en   = dtr_on && txc == TXC_IRQ;
    assign tx_allowed = (txc != TXC_OFF) && !cts_s;

    // Software reset clears command bits 4..0 only
    always_comb begin
        cmd_nxt = cmd_r;
        fmt_nxt = fmt_r;
        if (wr_cmd) cmd_nxt = data_in;
        if (wr_fmt) fmt_nxt = data_in;
        if (wr_stat) cmd_nxt = cmd_r & CMD_SWMASK;
    end

    // Format decode
    fmt_t f;
    always_comb begin
        f.nbits     = 4'h8 - {2'h0, fmt_r[FMT_WLEN +: 2]};
        f.par_en    = cmd_r[CMD_PAR];
        f.par_odd   = !cmd_r[CMD_PAR + 1];
        f.par_force = cmd_r[CMD_PAR + 2];
        f.par_level = !cmd_r[CMD_PAR + 1];
        if (!fmt_r[FMT_STOP])
            f.stop16 = 6'h10;
        else if (f.nbits == 4'h8 && f.par_en)
            f.stop16 = 6'h10;
        else if (f.nbits == 4'h5 && !f.par_en)
            f.stop16 = 6'h18;
        else
            f.stop16 = 6'h20;
    end

    // Transmitter
    tx_word_t  hold_r, hold_nxt;
    tx_state_t tx_st_r, tx_st_nxt;
    logic [10:0] tsh_r, tsh_nxt;
    logic [3:0]  tbit_r, tbit_nxt, tph_r, tph_nxt;
    logic [5:0]  tstop_r, tstop_nxt;
    logic        txd_r, txd_nxt, tx_ev, txe_r, txe_nxt;
    logic [7:0]  tmask;
    logic        tpar;
    assign tmask = 8'hFF >> (4'h8 - f.nbits);
    assign tpar  = f.par_force ? f.par_level : (^(hold_r.data & tmask)) ^ f.par_odd;

    always_comb begin
        hold_nxt  = hold_r;
        tx_st_nxt = tx_st_r;
        tsh_nxt   = tsh_r;
        tbit_nxt  = tbit_r;
        tph_nxt   = tph_r;
        tstop_nxt = tstop_r;
        txd_nxt   = txd_r;
        tx_ev     = 1'b0;
        txe_nxt   = txe_r;
        if (wr_data) begin
            hold_nxt = '{valid: 1'b1, data: data_in};
            txe_nxt  = 1'b0;
        end
        unique case (tx_st_r)
            TX_IDLE: begin
                txd_nxt = 1'b1;
                // Count first, so a load below restarts the bit phase
                if (tick) tph_nxt = tph_r + 4'h1;
                if (txc == TXC_BREAK && dtr_on && !cts_s) begin
                    tx_st_nxt = TX_BRK;
                end else if (hold_r.valid && tx_allowed && !wr_data) begin
                    // Load at once; start bit begins now
                    tsh_nxt   = {2'b11, tpar, hold_r.data & tmask};
                    hold_nxt.valid = 1'b0;
                    txe_nxt   = 1'b1;
                    tx_ev     = 1'b1;
                    txd_nxt   = 1'b0;
                    tbit_nxt  = 4'h0;
                    tph_nxt   = 4'h0;
                    tx_st_nxt = TX_SHIFT;
                end else if (tick && tph_r == OVS_LAST && tbit_r == 4'h0) begin
                    tx_ev = !hold_r.valid && txe_r;
                end
            end
            TX_SHIFT: begin
                if (!tx_allowed) begin
                    txd_nxt   = 1'b1;
                    tx_st_nxt = TX_IDLE;
                end else if (tick) begin
                    tph_nxt = tph_r + 4'h1;
                    if (tph_r == OVS_LAST) begin
                        tbit_nxt = tbit_r + 4'h1;
                        if (tbit_r < f.nbits) begin
                            txd_nxt = tsh_r[tbit_r[2:0]];
                        end else if (tbit_r == f.nbits && f.par_en) begin
                            txd_nxt = tsh_r[8];
                        end else begin
                            txd_nxt   = 1'b1;
                            tstop_nxt = 6'h00;
                            tbit_nxt  = 4'hF;
                        end
                    end
                    if (tbit_r == 4'hF) begin
                        // Stop time plus one extra sixteenth of mark
                        tstop_nxt = tstop_r + 6'h01;
                        if (tstop_r == f.stop16) begin
                            tx_st_nxt = TX_IDLE;
                            tph_nxt   = 4'h0;
                            tbit_nxt  = 4'h0;
                        end
                    end
                end
            end
            TX_BRK: begin
                txd_nxt = 1'b0;
                if (txc != TXC_BREAK || !dtr_on) begin
                    txd_nxt   = 1'b1;
                    tx_st_nxt = TX_IDLE;
                end
            end
            default: tx_st_nxt = TX_IDLE;
        endcase
    end

    // Receiver
    rx_state_t rx_st_r, rx_st_nxt;
    logic [7:0] rsh_r, rsh_nxt;
    logic [3:0] rbit_r, rbit_nxt, rph_r, rph_nxt;
    logic       rpar_r, rpar_nxt, rx_en, rx_done, rx_ev;
    logic       brk_wait_r, brk_wait_nxt;
    logic [2:0] rerr;
    logic       b_ready, b_valid, b_take;
    logic [10:0] b_out;
    logic [7:0] rx_holding_reg_r, rx_holding_reg_nxt;
    logic [2:0] err_r, err_nxt;
    logic       rxf_r, rxf_nxt, rd_seen_r, rd_seen_nxt;
    assign rx_en = dtr_on;

    always_comb begin
        rx_st_nxt    = rx_st_r;
        rsh_nxt      = rsh_r;
        rbit_nxt     = rbit_r;
        rph_nxt      = rph_r;
        rpar_nxt     = rpar_r;
        brk_wait_nxt = brk_wait_r;
        rx_done      = 1'b0;
        rerr         = 3'h0;
        if (tick) rph_nxt = rph_r + 4'h1;
        unique case (rx_st_r)
            RX_IDLE: begin
                if (brk_wait_r) begin
                    if (rxd_s) brk_wait_nxt = 1'b0;
                end else if (tick && rx_en && !rxd_s) begin
                    rph_nxt   = 4'h0;
                    rx_st_nxt = RX_START;
                end
            end
            RX_START: if (tick && rph_r == OVS_MID) begin
                // Short lows are glitches, not start bits
                rx_st_nxt = rxd_s ? RX_IDLE : RX_DATA;
                rph_nxt   = 4'h0;
                rbit_nxt  = 4'h0;
                rpar_nxt  = 1'b0;
                rsh_nxt   = 8'h00;
            end
            RX_DATA: if (tick && rph_r == OVS_LAST) begin
                rbit_nxt = rbit_r + 4'h1;
                if (rbit_r < f.nbits) begin
                    rsh_nxt[rbit_r[2:0]] = rxd_s;
                end else if (rbit_r == f.nbits && f.par_en) begin
                    rpar_nxt = rxd_s;
                end else begin
                    rx_st_nxt = RX_WAIT;
                    rph_nxt   = OVS_HALF;
                    rerr[ST_FRM] = !rxd_s;
                    rerr[ST_PAR] = f.par_en && !f.par_force &&
                                   ((^rsh_r) ^ rpar_r ^ f.par_odd);
                    brk_wait_nxt = !rxd_s && (rsh_r == 8'h00);
                end
            end
            RX_WAIT: if (tick && rph_r == RXIRQ_PT) begin
                rx_done   = 1'b1;
                rx_st_nxt = RX_IDLE;
            end
        endcase
        // Command-off lets a word finish; carrier loss drops it
        if (dcd_s) begin
            rx_st_nxt = RX_IDLE;
            rx_done   = 1'b0;
        end
    end

    logic [2:0] rerr_r, rerr_nxt;
    always_comb rerr_nxt = (rx_st_r == RX_DATA) ? rerr : rerr_r | rerr;

    // Overrun keeps the unread word; the newcomer is lost
    word_buf2 #(.W(11)) rx_buf (
        .mclk      (mclk),
        .nrst      (nrst),
        .flush     (wr_stat),
        .in_valid  (rx_done && !(rxf_r && !rd_data)),
        .in_ready  (b_ready),
        .in_data   ({rerr_r, rsh_r}),
        .out_valid (b_valid),
        .out_ready (b_take),
        .out_data  (b_out)
    );
    assign b_take = b_valid && (!rxf_r || rd_data);
    assign rx_ev  = rx_done;

    always_comb begin
        rx_holding_reg_nxt = rx_holding_reg_r;
        err_nxt     = err_r;
        rxf_nxt     = rxf_r;
        rd_seen_nxt = rd_seen_r || rd_data;
        if (rd_data) rxf_nxt = 1'b0;
        if (rx_done && (!b_ready || (rxf_r && !rd_data))) err_nxt[ST_OVR] = 1'b1;
        if (b_take) begin
            rx_holding_reg_nxt = b_out[7:0];
            rxf_nxt = 1'b1;
            // Sticky until a read is followed by a clean word
            err_nxt[ST_PAR] = b_out[8] | (err_r[ST_PAR] & !rd_seen_r);
            err_nxt[ST_FRM] = b_out[9] | (err_r[ST_FRM] & !rd_seen_r);
            if (rd_seen_r && !(rx_done && !b_ready)) err_nxt[ST_OVR] = 1'b0;
            rd_seen_nxt = 1'b0;
        end
        if (wr_stat) err_nxt[ST_OVR] = 1'b0;
    end

    // Modem change latch and interrupt
    logic dsr_lat_r, dsr_lat_nxt, dcd_lat_r, dcd_lat_nxt, irq_r, irq_nxt;
    always_comb begin
        dsr_lat_nxt = dsr_lat_r;
        dcd_lat_nxt = dcd_lat_r;
        irq_nxt     = irq_r;
        if (!irq_r) begin
            dsr_lat_nxt = dsr_s;
            dcd_lat_nxt = dcd_s;
        end
        if (rd_stat) irq_nxt = 1'b0;
        // A transmit or receive event wins over a clearing read in the same cycle
        if (dtr_on && !irq_r && (dsr_s != dsr_lat_r || dcd_s != dcd_lat_r))
            irq_nxt = 1'b1;
        if ((tx_ev && txirq_en) || (rx_ev && rxirq_en)) irq_nxt = 1'b1;
        if (!dtr_on) irq_nxt = 1'b0;
    end

    assign status = {irq_r, dsr_lat_r, dcd_lat_r, txe_r, rxf_r, err_r};

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            div_r    <= 16'h0000;
            acc_r    <= 1'b0;
            cmd_r    <= CMD_RST;
            fmt_r    <= FMT_RST;
            hold_r   <= '0;
            tx_st_r  <= TX_IDLE;
            tsh_r    <= '1;
            tbit_r   <= 4'h0;
            tph_r    <= 4'h0;
            tstop_r  <= 6'h00;
            txd_r    <= 1'b1;
            txe_r    <= 1'b1;
            rx_st_r  <= RX_IDLE;
            rsh_r    <= 8'h00;
            rbit_r   <= 4'h0;
            rph_r    <= 4'h0;
            rpar_r   <= 1'b0;
            rerr_r   <= 3'h0;
            brk_wait_r <= 1'b0;
            rx_holding_reg_r <= 8'h00;
            err_r    <= 3'h0;
            rxf_r    <= 1'b0;
            rd_seen_r <= 1'b0;
            dsr_lat_r <= 1'b1;
            dcd_lat_r <= 1'b1;
            irq_r    <= 1'b0;
            data_out <= 8'h00;
        end else begin
            div_r    <= div_nxt;
            acc_r    <= acc_nxt;
            cmd_r    <= cmd_nxt;
            fmt_r    <= fmt_nxt;
            hold_r   <= hold_nxt;
            tx_st_r  <= tx_st_nxt;
            tsh_r    <= tsh_nxt;
            tbit_r   <= tbit_nxt;
            tph_r    <= tph_nxt;
            tstop_r  <= tstop_nxt;
            txd_r    <= txd_nxt;
            txe_r    <= txe_nxt;
            rx_st_r  <= rx_st_nxt;
            rsh_r    <= rsh_nxt;
            rbit_r   <= rbit_nxt;
            rph_r    <= rph_nxt;
            rpar_r   <= rpar_nxt;
            rerr_r   <= rerr_nxt;
            brk_wait_r <= brk_wait_nxt;
            rx_holding_reg_r <= rx_holding_reg_nxt;
            err_r    <= err_nxt;
            rxf_r    <= rxf_nxt;
            rd_seen_r <= rd_seen_nxt;
            dsr_lat_r <= dsr_lat_nxt;
            dcd_lat_r <= dcd_lat_nxt;
            irq_r    <= irq_nxt;
            if (acc_start && rd_wr) begin
                unique case (sel)
                    SEL_DATA:   data_out <= rx_holding_reg_r;
                    SEL_STATUS: data_out <= status;
                    SEL_CMD:    data_out <= cmd_r;
                    SEL_FMT:    data_out <= fmt_r;
                endcase
            end
        end
    end

    assign data_oe = access && rd_wr && acc_r;
    assign irq_n   = !irq_r;
    assign txd     = txd_r;
    assign rts_n   = (txc == TXC_OFF);
    assign dtr_n   = !dtr_on;
endmodule

// File: testbench/serial_adaptor_checker.sv
// Port-level assertions for the serial adaptor core
`timescale 1ns/1ps
module serial_adaptor_checker
    import serial_adaptor_pkg::*;
#(
    parameter int DIV = DIV16
) (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       select_a,
    input wire logic       select_b_n,
    input wire logic       e_strobe,
    input wire logic       rd_wr,
    input wire logic       reg_sel_lo,
    input wire logic       reg_sel_hi,
    input wire logic [7:0] data_in,
    input wire logic       data_oe,
    input wire logic       irq_n,
    input wire logic       txd,
    input wire logic       rts_n,
    input wire logic       dtr_n,
    input wire logic       cts_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic       acc_r;
    logic [3:0] cts_h_r;
    wire        acc = select_a && !select_b_n && e_strobe;
    wire        start = acc && !acc_r;
    wire        wr_cmd = start && !rd_wr && {reg_sel_hi, reg_sel_lo} == SEL_CMD;
    // Sync delay: txd may lag a CTS change by a few cycles
    wire        cts_recent = cts_n || (|cts_h_r);
    always_ff @(posedge mclk) begin
        acc_r <= acc;
        cts_h_r <= {cts_h_r[2:0], cts_n};
    end
    property p_oe_qual; data_oe |-> acc && rd_wr; endproperty
    a_oe_qual: assert property (p_oe_qual) else $error("read drive outside read access");
    property p_oe_late; $rose(data_oe) |-> $past(start); endproperty
    a_oe_late: assert property (p_oe_late) else $error("read drive without access start");
    property p_dtr; wr_cmd |-> ##2 dtr_n == !$past(data_in[CMD_DTR], 2); endproperty
    a_dtr: assert property (p_dtr) else $error("terminal ready level wrong");
    property p_rts;
        wr_cmd |-> ##2 rts_n == ($past(data_in[CMD_TXC +: 2], 2) == TXC_OFF);
    endproperty
    a_rts: assert property (p_rts) else $error("send request level wrong");
    property p_swrst;
        start && !rd_wr && {reg_sel_hi, reg_sel_lo} == SEL_STATUS |-> ##2 dtr_n && rts_n;
    endproperty
    a_swrst: assert property (p_swrst) else $error("status write left lines active");
    property p_start_rts; $fell(txd) |-> !rts_n; endproperty
    a_start_rts: assert property (p_start_rts) else $error("word began with rts high");
    property p_cts; cts_n [*4] |=> txd; endproperty
    a_cts: assert property (p_cts) else $error("txd not mark without cts");
    property p_low_min; $fell(txd) |-> (!txd) [*8] or (##[0:8] cts_recent); endproperty
    a_low_min: assert property (p_low_min) else $error("short space on txd");
    property p_irq_dtr; $fell(irq_n) |-> !dtr_n; endproperty
    a_irq_dtr: assert property (p_irq_dtr) else $error("interrupt while not ready");
    c_irq: cover property ($fell(irq_n));
    c_cts: cover property (cts_n [*4] ##1 txd);
    c_cmd: cover property (wr_cmd ##2 !rts_n);
endmodule

bind async_serial_adaptor_core serial_adaptor_checker #(.DIV(DIV)) chk_inst (.*);

// File: testbench/modem_model.sv
// Modem-side model: word source on rxd, word collector on txd
`timescale 1ns/1ps
module modem_model #(
    parameter int BIT = 32
) (
    input  wire logic mclk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got_q[$];
    logic [7:0] w;
    initial rxd = 1'b1;
    // Start, 8 data LSB first, stop (bad if commanded), one idle mark
    task automatic send(input logic [7:0] d, input logic stop);
        for (int i = 0; i < 11; i++) begin
            rxd = (i == 0) ? 1'b0 : (i < 9) ? d[i-1] : (i == 9) ? stop : 1'b1;
            repeat (BIT) @(posedge mclk);
            #1;
        end
    endtask
    initial forever begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge mclk);
        if (!txd) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge mclk);
                w[i] = txd;
            end
            got_q.push_back(w);
            repeat (BIT) @(posedge mclk);
        end
    end
endmodule

// File: testbench/async_serial_adaptor_core_tb_top.sv
// Self-checking bench for the serial adaptor core
`timescale 1ns/1ps
module async_serial_adaptor_core_tb_top;
    import serial_adaptor_pkg::*;
    localparam int DV  = 2;
    localparam int BIT = OVS * DV;
    logic       mclk, nrst, select_a, select_b_n, e_strobe, rd_wr, reg_sel_lo, reg_sel_hi;
    logic       data_oe, irq_n, rxd, txd, rts_n, dtr_n, cts_n, dsr_n, dcd_n;
    logic [7:0] data_in, data_out, rd, a, b, c;
    logic [7:0] exp_q[$];
    int         fails, checks_done;

    async_serial_adaptor_core #(.DIV(DV)) async_serial_adaptor_core_inst (.*);
    modem_model #(.BIT(BIT)) modem_model_inst (.mclk(mclk), .txd(txd), .rxd(rxd));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic bus(input logic rw, input logic [1:0] s, input logic [7:0] wd);
        {select_a, select_b_n, e_strobe, rd_wr, reg_sel_hi, reg_sel_lo} = {3'h5, rw, s};
        data_in = wd;
        idle(2);
        rd = data_out;
        idle(1);
        {select_a, select_b_n, e_strobe} = 3'h2;
        idle(1);
    endtask
    task automatic rdchk(input logic [1:0] s, input logic [7:0] e, input string n);
        bus(1'b1, s, 8'h00);
        cmp8(n, e, rd);
    endtask
    task automatic chk_tx;
        cmp8("tx_count", 8'(exp_q.size()), 8'(modem_model_inst.got_q.size()));
        foreach (exp_q[i])
            if (i < modem_model_inst.got_q.size()) cmp8("tx_word", exp_q[i], modem_model_inst.got_q[i]);
        modem_model_inst.got_q.delete();
    endtask
    task automatic give_verdict;
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        idle(60000);
        fails++;
        give_verdict;
    end
    initial begin
        {nrst, select_a, select_b_n, e_strobe, rd_wr, reg_sel_lo, reg_sel_hi} = 7'h10;
        {cts_n, dsr_n, dcd_n} = 3'h0;
        data_in = 8'h00;
        fails = 0;
        checks_done = 0;
        a = $urandom(32'h9AD0);
        idle(16);
        nrst = 1'b1;
        idle(1);
        rdchk(SEL_STATUS, 8'h10, "status_rst");
        rdchk(SEL_CMD, CMD_RST, "cmd_rst");
        cmp8("dtr_n", 8'h01, dtr_n);
        for (int t = 0; t < 4; t++) begin
            bus(1'b0, SEL_CMD, {4'h0, 2'(t), 2'h1});
            cmp8("rts_n", {7'h00, t == 0}, rts_n);
        end
        idle(BIT);
        cmp8("txd_break", 8'h00, txd);
        bus(1'b0, SEL_CMD, 8'h09);
        idle(10 * BIT);
        bus(1'b1, SEL_STATUS, 8'h00);
        modem_model_inst.got_q.delete();
        a = $urandom;
        b = $urandom;
        c = $urandom;
        bus(1'b0, SEL_DATA, a);
        cmp8("txd_start", 8'h00, txd);
        rdchk(SEL_STATUS, 8'h10, "status_moved");
        bus(1'b0, SEL_DATA, b);
        rdchk(SEL_STATUS, 8'h00, "status_held");
        bus(1'b0, SEL_DATA, c);
        idle(22 * BIT);
        exp_q = '{a, c};
        chk_tx();
        bus(1'b0, SEL_FMT, 8'h60);
        bus(1'b0, SEL_DATA, a);
        idle(11 * BIT);
        exp_q = '{{3'h7, a[4:0]}};
        chk_tx();
        bus(1'b0, SEL_FMT, FMT_RST);
        bus(1'b0, SEL_DATA, b);
        bus(1'b0, SEL_DATA, c);
        idle(3 * BIT);
        cts_n = 1'b1;
        idle(5);
        cmp8("txd_cts", 8'h01, txd);
        idle(12 * BIT);
        modem_model_inst.got_q.delete();
        cts_n = 1'b0;
        idle(12 * BIT);
        exp_q = '{c};
        chk_tx();
        modem_model_inst.send(a, 1'b1);
        cmp8("irq_rx", 8'h00, irq_n);
        rdchk(SEL_STATUS, 8'h98, "status_rx");
        cmp8("irq_clr", 8'h01, irq_n);
        rdchk(SEL_DATA, a, "rx_word");
        rdchk(SEL_STATUS, 8'h10, "status_read");
        modem_model_inst.send(b, 1'b0);
        modem_model_inst.send(c, 1'b1);
        rdchk(SEL_STATUS, 8'h9E, "status_err");
        rdchk(SEL_DATA, b, "rx_kept");
        modem_model_inst.send(a, 1'b1);
        rdchk(SEL_STATUS, 8'h98, "status_clean");
        rdchk(SEL_DATA, a, "rx_next");
        dsr_n = 1'b1;
        idle(6);
        cmp8("irq_dsr", 8'h00, irq_n);
        dsr_n = 1'b0;
        idle(6);
        dsr_n = 1'b1;
        idle(6);
        rdchk(SEL_STATUS, 8'hD0, "status_dsr");
        idle(6);
        cmp8("irq_even", 8'h01, irq_n);
        dsr_n = 1'b0;
        idle(6);
        rdchk(SEL_STATUS, 8'h90, "status_dsr_on");
        fork
            modem_model_inst.send(c, 1'b1);
            begin
                idle(4 * BIT);
                dcd_n = 1'b1;
            end
        join
        dcd_n = 1'b0;
        idle(6);
        rdchk(SEL_STATUS, 8'hB0, "status_dcd");
        idle(6);
        rdchk(SEL_STATUS, 8'h90, "status_dcd_on");
        bus(1'b0, SEL_CMD, 8'h05);
        bus(1'b0, SEL_DATA, a);
        idle(4);
        cmp8("irq_tx", 8'h00, irq_n);
        bus(1'b1, SEL_STATUS, 8'h00);
        idle(12 * BIT);
        cmp8("irq_again", 8'h00, irq_n);
        bus(1'b0, SEL_STATUS, 8'hFF);
        rdchk(SEL_CMD, CMD_RST, "cmd_swrst");
        bus(1'b1, SEL_STATUS, 8'h00);
        dsr_n = 1'b1;
        idle(6);
        cmp8("irq_off", 8'h01, irq_n);
        give_verdict();
    end
endmodule
